/* rtl/pgc_defines.svh */
/*
 * Command codes, field positions, reset values and limits of the phase
 * placement and current gain trim commands.
 * Assumes it is included by bare name by the files that need it.
 */
`ifndef PGC_DEFINES_SVH
`define PGC_DEFINES_SVH

// ****************************************************************
// command codes
// ****************************************************************
`define PGC_CODE_PHASE      8'h37
`define PGC_CODE_GAIN       8'h38

// ****************************************************************
// phase placement layout
// ****************************************************************
`define PGC_PH_TOP_HI       15
`define PGC_PH_TOP_LO       12
`define PGC_PH_GRP_HI       11
`define PGC_PH_GRP_LO       8
`define PGC_PH_NUM_HI       7
`define PGC_PH_NUM_LO       4
`define PGC_PH_ORD_HI       3
`define PGC_PH_ORD_LO       0
`define PGC_PH_NUM_MIN      4'h1
`define PGC_PH_NUM_MAX      4'h4
`define PGC_PH_RESET        16'h0010

// ****************************************************************
// gain trim layout and limits
// ****************************************************************
`define PGC_GN_EXP_HI       15
`define PGC_GN_EXP_LO       11
`define PGC_GN_MAN_HI       10
`define PGC_GN_MAN_LO       0
`define PGC_GN_EXP_RESET    5'h19
`define PGC_GN_MAN_ONE      11'h080
`define PGC_GN_EXP_64TH     5'h1a
`define PGC_GN_Q_MAX        32'h0000_007f
`define PGC_GN_Q_HALF       32'h0000_0200
`define PGC_GN_Q_SHIFT      10
`define PGC_GN_FIX_FRAC     5'h10
`define PGC_GN_FIX_LIMIT    32'h0004_0000

`endif

/* rtl/pgc_pkg.sv */
/*
 * Types shared by the phase placement and gain trim command logic.
 * Assumes nothing of its surroundings.
 */
package pgc_pkg;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef logic [15:0] pgc_word_t;
	typedef logic [31:0] pgc_fix_t;

	// power-on load, command restore load, normal running
	typedef enum logic [1:0] {
		PGC_ST_POR,
		PGC_ST_LOAD,
		PGC_ST_RUN
	} pgc_state_e;

endpackage : pgc_pkg

/* rtl/pgc_sync2.sv */
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is a slow level such as a shared sync pulse train.
 */
`timescale 1ns/100ps

module pgc_sync2 #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta_r;

	// ****************************************************************
	// two stages; only the second stage reads the first
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			meta_r <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule : pgc_sync2

/* rtl/pgc_cmds.sv */
/*
 * Phase placement and output current gain trim command registers, with the
 * oscillator phase delay, gain applied telemetry and overcurrent compare.
 * Assumes a command decoder on the same clock presents one word access per
 * strobe, and that stacking configuration and stored values arrive on the
 * same clock; only the sync pin is asynchronous.
 */
// How it works
// - phase command: word write and word read
// - top four phase bits read as zero
// - group number 0..15, loaded from storage
// - group size 1..4 sets positions and step
// - order below group size, adds cycle/size
// - delay equals period times order over size
// - delay sits between sync and oscillator
// - phase command read-only in a stack
// - writability fixed at power-on stacking
// - storage or default init, live updates
// - gain trim: five-bit exponent, eleven-bit mantissa
// - telemetry equals sensed current times gain
// - gain change rescales overcurrent limits
// - bad gain write flagged, host notified
// - full resolution gain accepted in operation
// - restore rounds gain to 1/64, cap
`timescale 1ns/100ps
`include "pgc_defines.svh"

module pgc_cmds #(
	parameter int CNT_W = 16
) (
	input  wire logic             CLK_I,
	input  wire logic             RST_B_I,
	input  wire logic             CMD_VALID_I,
	input  wire logic             CMD_WRITE_I,
	input  wire logic [7:0]       CMD_CODE_I,
	input  wire pgc_pkg::pgc_word_t CMD_WDATA_I,
	output logic                  CMD_ACK_O,
	output pgc_pkg::pgc_word_t    CMD_RDATA_O,
	input  wire logic             CLEAR_FAULTS_I,
	output logic                  DATA_ERR_O,
	output logic                  ALERT_B_O,
	input  wire logic             NVM_RESTORE_I,
	input  wire pgc_pkg::pgc_word_t NVM_PHASE_I,
	input  wire pgc_pkg::pgc_word_t NVM_GAIN_I,
	input  wire logic             STACK_MULTI_I,
	output logic                  PHASE_WRITABLE_O,
	input  wire logic             SYNC_I,
	output logic                  OSC_START_O,
	input  wire logic [15:0]      SENSE_I,
	input  wire logic [15:0]      OC_FAULT_LIM_I,
	input  wire logic [15:0]      OC_WARN_LIM_I,
	output logic [15:0]           IOUT_O,
	output logic                  OC_FAULT_O,
	output logic                  OC_WARN_O
);
	import pgc_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	pgc_state_e       state_r;
	pgc_state_e       state_nxt;
	pgc_word_t        phase_r;
	pgc_word_t        phase_nxt;
	pgc_word_t        gain_r;
	pgc_word_t        gain_nxt;
	logic             lock_r;
	logic             err_r;
	logic             err_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] period_r;
	logic             fired_r;
	logic             sync_s;
	logic             sync_d_r;

	// ****************************************************************
	// gain conversion to unsigned 16.16 fixed point
	// ****************************************************************
	function automatic pgc_fix_t gain_fix(input pgc_word_t w);
		logic [4:0] sh;
		sh = w[`PGC_GN_EXP_HI:`PGC_GN_EXP_LO] + `PGC_GN_FIX_FRAC;
		gain_fix = pgc_fix_t'(w[`PGC_GN_MAN_HI:`PGC_GN_MAN_LO]) << sh;
	endfunction : gain_fix

	// positive mantissa, exponent -16..0, value below four
	function automatic logic gain_ok(input pgc_word_t w);
		logic [4:0] e;
		e = w[`PGC_GN_EXP_HI:`PGC_GN_EXP_LO];
		gain_ok = !w[`PGC_GN_MAN_HI] && (w[`PGC_GN_MAN_HI:`PGC_GN_MAN_LO] != 11'h000)
			&& (e[4] || e == 5'h00) && (gain_fix(w) < `PGC_GN_FIX_LIMIT);
	endfunction : gain_ok

	function automatic logic phase_ok(input pgc_word_t w);
		logic [3:0] n;
		n = w[`PGC_PH_NUM_HI:`PGC_PH_NUM_LO];
		phase_ok = (n >= `PGC_PH_NUM_MIN) && (n <= `PGC_PH_NUM_MAX)
			&& (w[`PGC_PH_ORD_HI:`PGC_PH_ORD_LO] < n);
	endfunction : phase_ok

	// ****************************************************************
	// command decode
	// ****************************************************************
	wire       wr_phase   = CMD_VALID_I && CMD_WRITE_I && (CMD_CODE_I == `PGC_CODE_PHASE);
	wire       wr_gain    = CMD_VALID_I && CMD_WRITE_I && (CMD_CODE_I == `PGC_CODE_GAIN);
	wire       rd_phase   = CMD_VALID_I && !CMD_WRITE_I && (CMD_CODE_I == `PGC_CODE_PHASE);
	wire       rd_gain    = CMD_VALID_I && !CMD_WRITE_I && (CMD_CODE_I == `PGC_CODE_GAIN);
	wire       hit        = wr_phase || wr_gain || rd_phase || rd_gain;
	wire       phase_good = phase_ok(CMD_WDATA_I);
	wire       gain_good  = gain_ok(CMD_WDATA_I);
	wire       take_phase = wr_phase && !lock_r && phase_good;
	wire       take_gain  = wr_gain && gain_good;
	wire       bad_write  = (wr_phase && !take_phase) || (wr_gain && !gain_good);
	wire       loading    = (state_r != PGC_ST_RUN);

	// top nibble forced to zero on read
	wire pgc_word_t rd_mux = rd_phase ? {4'h0, phase_r[`PGC_PH_GRP_HI:0]} :
		(rd_gain ? gain_r : 16'h0000);

	// ****************************************************************
	// stored value restore: phase validated, gain rounded to 1/64
	// ****************************************************************
	wire pgc_fix_t nvm_fix  = gain_fix(NVM_GAIN_I);
	wire pgc_fix_t nvm_q_rd = (nvm_fix + `PGC_GN_Q_HALF) >> `PGC_GN_Q_SHIFT;
	wire pgc_fix_t nvm_q    = (nvm_q_rd > `PGC_GN_Q_MAX) ? `PGC_GN_Q_MAX : nvm_q_rd;
	wire pgc_word_t nvm_gain = gain_ok(NVM_GAIN_I) ?
		{`PGC_GN_EXP_64TH, nvm_q[10:0]} : {`PGC_GN_EXP_RESET, `PGC_GN_MAN_ONE};
	wire pgc_word_t nvm_phase = phase_ok(NVM_PHASE_I) ?
		{4'h0, NVM_PHASE_I[`PGC_PH_GRP_HI:0]} : `PGC_PH_RESET;

	// ****************************************************************
	// next state of registers; a load overrides a write in its cycle
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		phase_nxt = phase_r;
		gain_nxt  = gain_r;
		case (state_r)
			PGC_ST_POR, PGC_ST_LOAD: begin
				phase_nxt = nvm_phase;
				gain_nxt  = nvm_gain;
				state_nxt = PGC_ST_RUN;
			end
			PGC_ST_RUN: begin
				if (NVM_RESTORE_I) begin
					state_nxt = PGC_ST_LOAD;
				end
				if (take_phase) begin
					phase_nxt = {4'h0, CMD_WDATA_I[`PGC_PH_GRP_HI:0]};
				end
				if (take_gain) begin
					gain_nxt = CMD_WDATA_I;
				end
			end
			default: begin
				state_nxt = PGC_ST_POR;
			end
		endcase
	end

	// sticky invalid-data flag; a new event beats a clear
	always_comb begin
		err_nxt = err_r;
		if (CLEAR_FAULTS_I) begin
			err_nxt = 1'b0;
		end
		if (bad_write) begin
			err_nxt = 1'b1;
		end
	end

	// ****************************************************************
	// register bank and bus answer
	// ****************************************************************
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			state_r     <= PGC_ST_POR;
			phase_r     <= `PGC_PH_RESET;
			gain_r      <= {`PGC_GN_EXP_RESET, `PGC_GN_MAN_ONE};
			err_r       <= 1'b0;
			ALERT_B_O   <= 1'b1;
			CMD_ACK_O   <= 1'b0;
			CMD_RDATA_O <= 16'h0000;
		end else begin
			state_r     <= state_nxt;
			phase_r     <= phase_nxt;
			gain_r      <= gain_nxt;
			err_r       <= err_nxt;
			ALERT_B_O   <= !err_nxt;
			CMD_ACK_O   <= hit;
			CMD_RDATA_O <= rd_mux;
		end
	end

	// stacking sampled once, in the first cycle after power-on reset
	// the writable pin is its own flop, loaded beside the lock
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			lock_r           <= 1'b1;
			PHASE_WRITABLE_O <= 1'b0;
		end else if (state_r == PGC_ST_POR) begin
			lock_r           <= STACK_MULTI_I;
			PHASE_WRITABLE_O <= !STACK_MULTI_I;
		end
	end

	// ****************************************************************
	// status outputs
	// ****************************************************************
	assign DATA_ERR_O = err_r;

	// ****************************************************************
	// sync pin, period measure and phase delayed oscillator start
	// ****************************************************************
	pgc_sync2 #(
		.RESET_VAL (1'b1)
	) u_sync (
		.clk_i   (CLK_I),
		.rst_b_i (RST_B_I),
		.async_i (SYNC_I),
		.sync_o  (sync_s)
	);

	wire                   sync_rise = sync_s && !sync_d_r;
	wire [3:0]             num_w     = phase_r[`PGC_PH_NUM_HI:`PGC_PH_NUM_LO];
	wire [3:0]             ord_w     = phase_r[`PGC_PH_ORD_HI:`PGC_PH_ORD_LO];
	wire [CNT_W+3:0]       elapsed   = cnt_r * num_w;
	wire [CNT_W+3:0]       target    = period_r * ord_w;
	wire                   fire      = !fired_r && (elapsed >= target);
	wire [CNT_W-1:0]       cnt_inc   = (cnt_r == {CNT_W{1'b1}}) ? cnt_r : cnt_r + 1'b1;

	// counter restarts on each sync rising edge; the edge detector resets
	// high with the synchroniser, so a pin already high at release is no edge
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			sync_d_r    <= 1'b1;
			cnt_r       <= '0;
			period_r    <= '0;
			fired_r     <= 1'b1;
			OSC_START_O <= 1'b0;
		end else begin
			sync_d_r    <= sync_s;
			cnt_r       <= sync_rise ? '0 : cnt_inc;
			period_r    <= sync_rise ? cnt_inc : period_r;
			fired_r     <= sync_rise ? 1'b0 : (fired_r || fire);
			OSC_START_O <= fire && !sync_rise;
		end
	end

	// ****************************************************************
	// gain applied telemetry and overcurrent compare
	// ****************************************************************
	wire pgc_fix_t    gfix   = gain_fix(gain_r);
	wire [47:0]       prod   = SENSE_I * gfix;
	wire [15:0]       iout_w = (prod[47:32] != 16'h0000) ? 16'hffff : prod[31:16];

	// comparing gained current against limits rescales the raw limits
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			IOUT_O     <= 16'h0000;
			OC_FAULT_O <= 1'b0;
			OC_WARN_O  <= 1'b0;
		end else begin
			IOUT_O     <= iout_w;
			OC_FAULT_O <= (iout_w >= OC_FAULT_LIM_I);
			OC_WARN_O  <= (iout_w >= OC_WARN_LIM_I);
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	top_zero_a: assert property (rd_phase |=> CMD_ACK_O && CMD_RDATA_O[15:12] == 4'h0)
		else $error("phase read top nibble not zero");
	locked_write_a: assert property (wr_phase && lock_r && !loading |=> $stable(phase_r) && err_r)
		else $error("phase write taken while stacked");
	stack_frozen_a: assert property (state_r != PGC_ST_POR |=> $stable(lock_r))
		else $error("stacking lock changed after power-on");
	bad_order_a: assert property (wr_phase && !phase_good && !loading |=> $stable(phase_r) && DATA_ERR_O)
		else $error("bad phase size or order accepted");
	gain_bad_a: assert property (wr_gain && !gain_good |=> DATA_ERR_O && !ALERT_B_O)
		else $error("bad gain write not flagged");
	gain_take_a: assert property (take_gain && !loading |=> gain_r == $past(CMD_WDATA_I))
		else $error("valid gain write lost");
	round_cap_a: assert property (loading && gain_ok(NVM_GAIN_I) |=> gain_r[15:11] == 5'h1a && gain_r[10:7] == 4'h0)
		else $error("restored gain not on 1/64 grid below 2");
	unity_gain_a: assert property (gain_r == 16'hc880 && $stable(gain_r) |=> IOUT_O == $past(SENSE_I))
		else $error("unity gain changes telemetry");
	zero_phase_a: assert property (sync_rise && ord_w == 4'h0 && $stable(phase_r) |-> ##2 OSC_START_O)
		else $error("zero order start not at sync edge");
	set_wins_a: assert property (bad_write && CLEAR_FAULTS_I |=> err_r)
		else $error("clear beat a new invalid data event");
	alert_pair_a: assert property (ALERT_B_O != DATA_ERR_O)
		else $error("notify level disagrees with invalid data flag");
	writable_lock_a: assert property (state_r == PGC_ST_RUN |-> PHASE_WRITABLE_O != lock_r)
		else $error("writable pin disagrees with stacking lock");

	locked_write_c: cover property (wr_phase && lock_r);
	gain_write_c: cover property (take_gain ##1 IOUT_O != 16'h0000);
	mid_phase_c: cover property (OSC_START_O && ord_w == 4'h2 && num_w == 4'h4);
	restore_c: cover property (state_r == PGC_ST_LOAD);
	set_wins_c: cover property (bad_write && CLEAR_FAULTS_I);

endmodule : pgc_cmds

/* test/pgc_host_model.sv */
/*
 * Host model: issues one word access per strobe on the command port and
 * collects the acknowledge and read word.
 * Assumes the command port of pgc_cmds on the same clock.
 */
`timescale 1ns/100ps

module pgc_host_model (
	input  wire logic               clk_i,
	input  wire logic               ack_i,
	input  wire pgc_pkg::pgc_word_t rdata_i,
	output logic                    valid_o,
	output logic                    write_o,
	output logic [7:0]              code_o,
	output pgc_pkg::pgc_word_t      wdata_o
);
	import pgc_pkg::*;

	// idle bus at time zero
	initial begin
		valid_o = 1'b0;
		write_o = 1'b0;
		code_o = 8'h00;
		wdata_o = 16'h0000;
	end

	// one word write or read: one-cycle strobe, bounded wait for the ack
	task automatic access(input logic wr, input logic [7:0] code, input pgc_word_t wd,
		output pgc_word_t rd, output logic acked);
		acked = 1'b0;
		rd = 16'h0000;
		@(negedge clk_i);
		valid_o = 1'b1;
		write_o = wr;
		code_o = code;
		wdata_o = wd;
		@(negedge clk_i);
		valid_o = 1'b0;
		wdata_o = ~wd; // released data must not keep its last value
		for (int i = 0; i < 4 && !acked; i++) begin
			if (ack_i === 1'b1) begin
				acked = 1'b1;
				rd = rdata_i;
			end else
				@(negedge clk_i);
		end
	endtask : access
endmodule : pgc_host_model

/* test/tb.sv */
/*
 * Self-checking bench for the phase placement and gain trim commands.
 * Assumes pgc_cmds, the host model and one 50 MHz clock.
 */
`timescale 1ns/100ps

module tb;
	import pgc_pkg::*;
	typedef struct {
		logic       wr;
		logic [7:0] code;
		pgc_word_t  wd;
		pgc_word_t  exp;
		logic       err;
	} pgc_row_s;
	logic clk = 1'b0, rst_b = 1'b0, valid, wr, ack, clr = 1'b0, err, alert_b;
	logic restore = 1'b0, stack = 1'b0, wrt, sync = 1'b0, osc, ocf, ocw;
	logic [7:0] code;
	pgc_word_t wdata, rdata, nvm_ph = 16'h0321, nvm_gn = 16'hc880;
	logic [15:0] sense = 16'h0000, lim_f = 16'h0096, lim_w = 16'h0078, iout;
	int miscompares = 0, cmp_count = 0;
	logic [3:0] nums [10] = '{4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h4, 4'h4, 4'h4, 4'h4};
	logic [3:0] ords [10] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h2, 4'h0, 4'h1, 4'h2, 4'h3};
	pgc_row_s rows [11] = '{
		'{1'b0, 8'h37, 16'h0000, 16'h0321, 1'b0},
		'{1'b0, 8'h38, 16'h0000, 16'hd040, 1'b0},
		'{1'b1, 8'h37, 16'hf042, 16'h0042, 1'b0},
		'{1'b1, 8'h37, 16'h0f10, 16'h0f10, 1'b0},
		'{1'b1, 8'h37, 16'h0050, 16'h0f10, 1'b1},
		'{1'b1, 8'h37, 16'h0022, 16'h0f10, 1'b1},
		'{1'b1, 8'h37, 16'h0000, 16'h0f10, 1'b1},
		'{1'b1, 8'h38, 16'hc8c0, 16'hc8c0, 1'b0},
		'{1'b1, 8'h38, 16'hca00, 16'hc8c0, 1'b1},
		'{1'b1, 8'h38, 16'hcc00, 16'hc8c0, 1'b1},
		'{1'b1, 8'h38, 16'h0001, 16'h0001, 1'b0}
	};

	// ****************************************************************
	// clock, sync pin and instances
	// ****************************************************************
	initial begin
		forever #10 clk = ~clk;
	end
	// sync pin with a period of 48 cycles
	initial begin
		forever begin
			repeat (24) @(negedge clk);
			sync = ~sync;
		end
	end
	pgc_host_model pgc_host_model_i (.clk_i(clk), .ack_i(ack), .rdata_i(rdata),
		.valid_o(valid), .write_o(wr), .code_o(code), .wdata_o(wdata));
	pgc_cmds pgc_cmds_i (.CLK_I(clk), .RST_B_I(rst_b), .CMD_VALID_I(valid), .CMD_WRITE_I(wr),
		.CMD_CODE_I(code), .CMD_WDATA_I(wdata), .CMD_ACK_O(ack), .CMD_RDATA_O(rdata),
		.CLEAR_FAULTS_I(clr), .DATA_ERR_O(err), .ALERT_B_O(alert_b),
		.NVM_RESTORE_I(restore), .NVM_PHASE_I(nvm_ph), .NVM_GAIN_I(nvm_gn),
		.STACK_MULTI_I(stack), .PHASE_WRITABLE_O(wrt), .SYNC_I(sync), .OSC_START_O(osc),
		.SENSE_I(sense), .OC_FAULT_LIM_I(lim_f), .OC_WARN_LIM_I(lim_w), .IOUT_O(iout),
		.OC_FAULT_O(ocf), .OC_WARN_O(ocw));

	// ****************************************************************
	// helper tasks
	// ****************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	// access that must be acknowledged
	task automatic acc(input logic w, input logic [7:0] c, input pgc_word_t d,
		output pgc_word_t r);
		logic a;
		pgc_host_model_i.access(w, c, d, r, a);
		check(16'(a), 16'h0001);
	endtask : acc

	// reset for 12 cycles with the given stacking level, outputs checked in reset
	task automatic reset_dut(input logic stk);
		@(negedge clk);
		rst_b = 1'b0;
		stack = stk;
		repeat (12) @(negedge clk);
		check(16'({ack, wrt, alert_b, osc, ocf, ocw}), 16'h0008);
		check(iout, 16'h0000);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
	endtask : reset_dut

	// cycles from a sync rise to the next oscillator start
	task automatic meas(output int d);
		d = -1;
		@(posedge sync);
		for (int i = 0; i < 48 && d < 0; i++) begin
			@(negedge clk);
			if (osc === 1'b1)
				d = i;
		end
	endtask : meas

	// restore from storage and read the rounded gain back
	task automatic restore_chk(input pgc_word_t gn, input pgc_word_t exp,
		input pgc_word_t ph, input pgc_word_t exp_ph);
		pgc_word_t r;
		nvm_gn = gn;
		nvm_ph = ph;
		@(negedge clk);
		restore = 1'b1;
		@(negedge clk);
		restore = 1'b0;
		repeat (3) @(negedge clk);
		acc(1'b0, 8'h38, 16'h0000, r);
		check(r, exp);
		acc(1'b0, 8'h37, 16'h0000, r);
		check(r, exp_ph);
	endtask : restore_chk

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		pgc_word_t rd;
		logic a;
		int d, d0;
		d0 = 0;
		reset_dut(1'b0);
		check(16'(wrt), 16'h0001);
		foreach (rows[n]) begin
			@(negedge clk);
			clr = 1'b1;
			@(negedge clk);
			clr = 1'b0;
			if (rows[n].wr)
				acc(1'b1, rows[n].code, rows[n].wd, rd);
			acc(1'b0, rows[n].code, 16'h0000, rd);
			check(rd, rows[n].exp);
			check(16'({err, alert_b}), 16'({rows[n].err, !rows[n].err}));
		end
		pgc_host_model_i.access(1'b0, 8'h39, 16'h0000, rd, a);
		check(16'(a), 16'h0000);
		$display("test table done");
		sense = 16'h0064;
		acc(1'b1, 8'h38, 16'hc880, rd);
		repeat (2) @(negedge clk);
		check(iout, 16'h0064);
		check(16'({ocf, ocw}), 16'h0000);
		acc(1'b1, 8'h38, 16'hc8a0, rd);
		repeat (2) @(negedge clk);
		check(iout, 16'h007d);
		check(16'({ocf, ocw}), 16'h0001);
		acc(1'b1, 8'h38, 16'hc8c0, rd);
		repeat (2) @(negedge clk);
		check(iout, 16'h0096);
		check(16'({ocf, ocw}), 16'h0003);
		$display("test telemetry done");
		restore_chk(16'hcc00, 16'hc880, 16'h0050, 16'h0010);
		restore_chk(16'hc183, 16'hd061, 16'h0130, 16'h0130);
		restore_chk(16'hc8ff, 16'hd07f, 16'h0130, 16'h0130);
		$display("test restore done");
		for (int k = 0; k < 10; k++) begin
			acc(1'b1, 8'h37, {8'h00, nums[k], ords[k]}, rd);
			repeat (3) meas(d);
			if (ords[k] == 4'h0)
				d0 = d;
			check(16'(d >= 0), 16'h0001);
			check(16'(d), 16'(d0 + 48 * ords[k] / nums[k]));
		end
		$display("test oscillator done");
		stack = 1'b1;
		acc(1'b1, 8'h37, 16'h0010, rd);
		check(16'(err), 16'h0000);
		acc(1'b0, 8'h37, 16'h0000, rd);
		check(rd, 16'h0010);
		reset_dut(1'b1);
		check(16'(wrt), 16'h0000);
		// clear pulse in the very cycle of the refused write: the set must win
		fork
			begin
				@(negedge clk);
				clr = 1'b1;
				@(negedge clk);
				clr = 1'b0;
			end
			acc(1'b1, 8'h37, 16'h0021, rd);
		join
		acc(1'b0, 8'h37, 16'h0000, rd);
		check(rd, 16'h0130);
		check(16'(err), 16'h0001);
		check(16'(alert_b), 16'h0000);
		$display("test stacking done");
		finish_test();
	end

	// watchdog well beyond the expected run of under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("ERROR at %0t: timeout", $time);
		finish_test();
	end
endmodule : tb
